// [srac_consts.svh]
`ifndef SRAC_CONSTS_SVH
`define SRAC_CONSTS_SVH
// ***********************************************************
// Frame coding
// ***********************************************************
`define SRAC_SYNC_BYTE 8'h55
`define SRAC_CRC_SEED 8'hff
`define SRAC_CRC_POLY 8'h07
`define SRAC_HDR_RW_BIT 7
`define SRAC_HDR_BCAST_BIT 6
`define SRAC_BUF_DEPTH 24
// ***********************************************************
// Device register offsets and reset values
// ***********************************************************
`define SRAC_ADR_CMD 8'h91
`define SRAC_ADR_ACK_CFG 8'h92
`define SRAC_ADR_GUARD 8'h93
`define SRAC_ADR_CTRL_GATE 8'h96
`define SRAC_ADR_NVM_CTRL 8'h97
`define SRAC_ADR_NVM_GATE 8'h98
`define SRAC_ADR_IDENT 8'h86
`define SRAC_ADR_FLAG_ERR 8'ha0
`define SRAC_CMD_RESTORE_BIT 0
`define SRAC_CMD_FORCE_FS_BIT 1
`define SRAC_CMD_RELOAD_BIT 2
`define SRAC_GUARD_BRT_BIT 0
`define SRAC_GUARD_CUR_BIT 1
`define SRAC_GUARD_CFG_BIT 2
`define SRAC_IDENT_INT_BIT 4
`define SRAC_GUARD_DEFAULT 8'h06
`define SRAC_ACK_CFG_DEFAULT 8'h01
`define SRAC_FLAG_ERR_DEFAULT 8'h01
`define SRAC_NV_DEFAULT 8'ha5
`define SRAC_CKEY0 8'h43
`define SRAC_CKEY1 8'h4f
`define SRAC_CKEY2 8'h44
`define SRAC_CKEY3 8'h45
`define SRAC_NKEY0 8'h00
`define SRAC_NKEY1 8'h04
`define SRAC_NKEY2 8'h02
`define SRAC_NKEY3 8'h09
`define SRAC_NKEY4 8'h02
`define SRAC_NKEY5 8'h09
`define SRAC_CKEY_LEN 3'd4
`define SRAC_NKEY_LEN 3'd6
// ***********************************************************
// Host controller register offsets
// ***********************************************************
`define SRAC_H_CMD 8'h00
`define SRAC_H_STAT 8'h04
`define SRAC_H_BUF 8'h40
`define SRAC_H_CMD_GO_BIT 31
`define SRAC_H_CMD_ACK_BIT 16
`define SRAC_RSP_TIMEOUT 8'd200
`endif

// [srac_pkg.sv]
`include "srac_consts.svh"
package srac_pkg;
  typedef enum logic [2:0] {
    SRAC_GRP_NONE, SRAC_GRP_BRT, SRAC_GRP_CUR, SRAC_GRP_CFG, SRAC_GRP_CFG_NV, SRAC_GRP_CTRL,
    SRAC_GRP_FLAG
  } srac_grp_e;
  typedef enum logic [2:0] {
    SRAC_D_IDLE = 3'b000, SRAC_D_HDR = 3'b001, SRAC_D_ADR = 3'b011, SRAC_D_DATA = 3'b010,
    SRAC_D_CRC = 3'b110, SRAC_D_COMMIT = 3'b111, SRAC_D_REPLY = 3'b101
  } srac_dev_state_e;
  typedef enum logic [2:0] {
    SRAC_H_IDLE = 3'b000, SRAC_H_SYNC = 3'b001, SRAC_H_HDR = 3'b011, SRAC_H_ADR = 3'b010,
    SRAC_H_DATA = 3'b110, SRAC_H_CRC = 3'b111, SRAC_H_WAIT = 3'b101
  } srac_host_state_e;

  function automatic logic [7:0] srac_crc_step(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `SRAC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [4:0] srac_len_bytes(input logic [1:0] code);
    case (code)
      2'b00: return 5'd1;
      2'b01: return 5'd4;
      2'b10: return 5'd16;
      default: return 5'd24;
    endcase
  endfunction

  function automatic srac_grp_e srac_group_of(input logic [7:0] a);
    if (a <= 8'h17 || (a >= 8'h20 && a <= 8'h37) || (a >= 8'h40 && a <= 8'h44)) begin
      return SRAC_GRP_BRT;
    end else if (a >= 8'h50 && a <= 8'h67) begin
      return SRAC_GRP_CUR;
    end else if (a >= 8'h70 && a <= 8'h83) begin
      return SRAC_GRP_CFG;
    end else if (a >= 8'h84 && a <= 8'h87) begin
      return SRAC_GRP_CFG_NV;
    end else if (a >= 8'h90 && a <= 8'h98) begin
      return SRAC_GRP_CTRL;
    end else if (a >= 8'ha0 && a <= 8'haf) begin
      return SRAC_GRP_FLAG;
    end
    return SRAC_GRP_NONE;
  endfunction
endpackage

// [srac_link_if.sv]
`timescale 1ns/100ps
interface srac_link_if;
  logic h2d_vld;
  logic [7:0] h2d_byte;
  logic d2h_vld;
  logic [7:0] d2h_byte;
  logic d2h_busy;
  modport dev (input h2d_vld, input h2d_byte, output d2h_vld, output d2h_byte, output d2h_busy);
  modport host (output h2d_vld, output h2d_byte, input d2h_vld, input d2h_byte, input d2h_busy);
endinterface

// [srac_device.sv]
// Notes on behaviour
// - Host ends frame with check byte
// - Bad check byte drops frame, no watchdog
// - Check code starts from all ones
// - Burst write fills consecutive addresses
// - Burst read returns consecutive addresses
// - Group write-protect bits guard writes
// - 84h-87h writable only in program mode
// - Control key sequence opens 92h-95h
// - Control gate write closes, resets guard
// - Nonvolatile key sequence opens 97h
// - Host relocks groups after writing
// - Brightness clears on reset, restore
// - Brightness reloads on four events
// - Current, config reload on six events
// - Control, flags default at restart; guard also on watchdog, fail-safe, gate write
// - Fail-safe resets guard; program clears
// - Select pin forces address zero
// - Device uses strap address unless 86h bit 4 selects 86h[3:0]; broadcast only for writes
// - Length field picks 1/4/16/24 bytes
// - Matched write acknowledged with status if 92h bit 0 set and not broadcast
// - Every frame starts with sync byte
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
`include "srac_consts.svh"
module srac_device import srac_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ref_sel_i,
  input wire logic [2:0] addr_strap_i,
  input wire logic uvlo_restart_i,
  input wire logic wdt_overflow_i,
  output logic wdt_restart_o,
  output logic nvm_program_mode_o,
  srac_link_if.dev link
);
  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r, pin_q_nxt;
  always_comb begin
    pin_q_nxt = (pin_s2_r == pin_s3_r) ? pin_s3_r : pin_q_r;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      pin_s3_r <= 4'h0;
      pin_q_r <= 4'h0;
    end else begin
      pin_s1_r <= {ref_sel_i, addr_strap_i};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_q_r <= pin_q_nxt;
    end
  end

  // ***********************************************************
  // Frame engine
  // ***********************************************************
  logic [7:0] regs [0:255];
  logic [7:0] nv [0:255];
  logic [7:0] buf_r [0:`SRAC_BUF_DEPTH-1];
  srac_dev_state_e state_r, state_nxt;
  logic [7:0] hdr_r, hdr_nxt, radr_r, radr_nxt, crc_r, crc_nxt;
  logic [4:0] cnt_r, cnt_nxt, len;
  logic [2:0] ckey_r, ckey_nxt, nkey_r, nkey_nxt;
  logic copen_r, copen_nxt, nopen_r, nopen_nxt, wdt_nxt;
  logic tx_vld_r, tx_vld_nxt, busy_r, busy_nxt;
  logic [7:0] tx_byte_r, tx_byte_nxt;
  logic [7:0] cadr, cdat, my_addr;
  logic match, is_wr, single, we, allowed, ackreq;
  logic ev_restore, ev_force, ev_reload, ev_prog, brt_reload, cc_reload;

  function automatic logic [7:0] ckey_byte(input logic [2:0] i);
    case (i)
      3'd0: return `SRAC_CKEY0;
      3'd1: return `SRAC_CKEY1;
      3'd2: return `SRAC_CKEY2;
      default: return `SRAC_CKEY3;
    endcase
  endfunction

  function automatic logic [7:0] nkey_byte(input logic [2:0] i);
    case (i)
      3'd0: return `SRAC_NKEY0;
      3'd1: return `SRAC_NKEY1;
      3'd2: return `SRAC_NKEY2;
      3'd3: return `SRAC_NKEY3;
      3'd4: return `SRAC_NKEY4;
      default: return `SRAC_NKEY5;
    endcase
  endfunction

  always_comb begin
    len = srac_len_bytes(hdr_r[5:4]);
    is_wr = hdr_r[`SRAC_HDR_RW_BIT];
    single = (hdr_r[5:4] == 2'b00);
    my_addr = regs[`SRAC_ADR_IDENT][`SRAC_IDENT_INT_BIT] ? {4'h0, regs[`SRAC_ADR_IDENT][3:0]} :
              {4'h0, regs[`SRAC_ADR_IDENT][3], pin_q_r[2:0]};
    if (pin_q_r[3]) begin
      match = (hdr_r[3:0] == 4'h0) && !hdr_r[`SRAC_HDR_BCAST_BIT];
    end else if (hdr_r[`SRAC_HDR_BCAST_BIT]) begin
      match = (hdr_r[3:0] == 4'h0) && is_wr;
    end else begin
      match = ({4'h0, hdr_r[3:0]} == my_addr);
    end
    ackreq = !hdr_r[`SRAC_HDR_BCAST_BIT] && regs[`SRAC_ADR_ACK_CFG][0];
    cadr = radr_r + {3'h0, cnt_r};
    cdat = buf_r[cnt_r];
    case (srac_group_of(cadr))
      SRAC_GRP_BRT: allowed = !regs[`SRAC_ADR_GUARD][`SRAC_GUARD_BRT_BIT];
      SRAC_GRP_CUR: allowed = !regs[`SRAC_ADR_GUARD][`SRAC_GUARD_CUR_BIT];
      SRAC_GRP_CFG: allowed = !regs[`SRAC_ADR_GUARD][`SRAC_GUARD_CFG_BIT];
      SRAC_GRP_CFG_NV: allowed = nvm_program_mode_o;
      SRAC_GRP_CTRL: begin
        if (cadr >= 8'h92 && cadr <= 8'h95) allowed = copen_r;
        else if (cadr == `SRAC_ADR_NVM_CTRL) allowed = nopen_r;
        else allowed = 1'b1;
      end
      default: allowed = 1'b0;
    endcase
    we = (state_r == SRAC_D_COMMIT) && allowed;
    ev_restore = we && cadr == `SRAC_ADR_CMD && cdat[`SRAC_CMD_RESTORE_BIT];
    ev_force = we && cadr == `SRAC_ADR_CMD && cdat[`SRAC_CMD_FORCE_FS_BIT];
    ev_reload = we && cadr == `SRAC_ADR_CMD && cdat[`SRAC_CMD_RELOAD_BIT];
    ev_prog = we && cadr == `SRAC_ADR_NVM_CTRL && cdat[0] && !nvm_program_mode_o;
    brt_reload = wdt_overflow_i || ev_force || ev_reload || ev_prog;
    cc_reload = uvlo_restart_i || brt_reload || ev_restore;

    state_nxt = state_r;
    hdr_nxt = hdr_r;
    radr_nxt = radr_r;
    crc_nxt = crc_r;
    cnt_nxt = cnt_r;
    ckey_nxt = ckey_r;
    nkey_nxt = nkey_r;
    copen_nxt = copen_r;
    nopen_nxt = nopen_r;
    wdt_nxt = 1'b0;
    tx_vld_nxt = 1'b0;
    tx_byte_nxt = tx_byte_r;
    unique case (state_r)
      SRAC_D_IDLE: begin
        if (link.h2d_vld && link.h2d_byte == `SRAC_SYNC_BYTE) begin
          crc_nxt = `SRAC_CRC_SEED;
          state_nxt = SRAC_D_HDR;
        end
      end
      SRAC_D_HDR: begin
        if (link.h2d_vld) begin
          hdr_nxt = link.h2d_byte;
          crc_nxt = srac_crc_step(crc_r, link.h2d_byte);
          state_nxt = SRAC_D_ADR;
        end
      end
      SRAC_D_ADR: begin
        if (link.h2d_vld) begin
          radr_nxt = link.h2d_byte;
          crc_nxt = srac_crc_step(crc_r, link.h2d_byte);
          cnt_nxt = 5'd0;
          state_nxt = is_wr ? SRAC_D_DATA : SRAC_D_CRC;
        end
      end
      SRAC_D_DATA: begin
        if (link.h2d_vld) begin
          crc_nxt = srac_crc_step(crc_r, link.h2d_byte);
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == len - 5'd1) state_nxt = SRAC_D_CRC;
        end
      end
      SRAC_D_CRC: begin
        if (link.h2d_vld) begin
          cnt_nxt = 5'd0;
          crc_nxt = `SRAC_CRC_SEED;
          if (link.h2d_byte != crc_r || !match) begin
            state_nxt = SRAC_D_IDLE;
          end else begin
            wdt_nxt = 1'b1;
            state_nxt = is_wr ? SRAC_D_COMMIT : SRAC_D_REPLY;
          end
        end
      end
      SRAC_D_COMMIT: begin
        if (cadr == `SRAC_ADR_CTRL_GATE) begin
          copen_nxt = 1'b0;
          if (!single) ckey_nxt = 3'd0;
          else if (cdat == ckey_byte(ckey_r)) begin
            ckey_nxt = (ckey_r + 3'd1 == `SRAC_CKEY_LEN) ? 3'd0 : ckey_r + 3'd1;
            copen_nxt = (ckey_r + 3'd1 == `SRAC_CKEY_LEN);
          end else ckey_nxt = (cdat == ckey_byte(3'd0)) ? 3'd1 : 3'd0;
        end
        if (cadr == `SRAC_ADR_NVM_GATE) begin
          nopen_nxt = 1'b0;
          if (!single) nkey_nxt = 3'd0;
          else if (cdat == nkey_byte(nkey_r)) begin
            nkey_nxt = (nkey_r + 3'd1 == `SRAC_NKEY_LEN) ? 3'd0 : nkey_r + 3'd1;
            nopen_nxt = (nkey_r + 3'd1 == `SRAC_NKEY_LEN);
          end else nkey_nxt = (cdat == nkey_byte(3'd0)) ? 3'd1 : 3'd0;
        end
        cnt_nxt = cnt_r + 5'd1;
        if (cnt_r == len - 5'd1) begin
          cnt_nxt = 5'd0;
          state_nxt = ackreq ? SRAC_D_REPLY : SRAC_D_IDLE;
        end
      end
      SRAC_D_REPLY: begin
        tx_vld_nxt = 1'b1;
        cnt_nxt = cnt_r + 5'd1;
        if ((is_wr && cnt_r == 5'd0) || (!is_wr && cnt_r < len)) begin
          tx_byte_nxt = is_wr ? regs[`SRAC_ADR_FLAG_ERR] : regs[cadr];
          crc_nxt = srac_crc_step(crc_r, tx_byte_nxt);
        end else begin
          tx_byte_nxt = crc_r;
          state_nxt = SRAC_D_IDLE;
        end
      end
      default: state_nxt = SRAC_D_IDLE;
    endcase
    // Busy covers the closing check byte as well
    busy_nxt = (state_nxt == SRAC_D_COMMIT) || (state_nxt == SRAC_D_REPLY) || tx_vld_nxt;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= SRAC_D_IDLE;
      hdr_r <= 8'h00;
      radr_r <= 8'h00;
      crc_r <= `SRAC_CRC_SEED;
      cnt_r <= 5'd0;
      ckey_r <= 3'd0;
      nkey_r <= 3'd0;
      copen_r <= 1'b0;
      nopen_r <= 1'b0;
      wdt_restart_o <= 1'b0;
      tx_vld_r <= 1'b0;
      tx_byte_r <= 8'h00;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hdr_r <= hdr_nxt;
      radr_r <= radr_nxt;
      crc_r <= crc_nxt;
      cnt_r <= cnt_nxt;
      ckey_r <= ckey_nxt;
      nkey_r <= nkey_nxt;
      copen_r <= copen_nxt;
      nopen_r <= nopen_nxt;
      wdt_restart_o <= wdt_nxt;
      tx_vld_r <= tx_vld_nxt;
      tx_byte_r <= tx_byte_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ***********************************************************
  // Payload buffer and register array
  // ***********************************************************
  always_ff @(posedge core_clk_i) begin
    if (state_r == SRAC_D_DATA && link.h2d_vld) buf_r[cnt_r] <= link.h2d_byte;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 256; i++) begin
        nv[i] <= `SRAC_NV_DEFAULT;
        case (srac_group_of(8'(i)))
          SRAC_GRP_CUR, SRAC_GRP_CFG, SRAC_GRP_CFG_NV: regs[i] <= `SRAC_NV_DEFAULT;
          default: regs[i] <= 8'h00;
        endcase
      end
      regs[`SRAC_ADR_GUARD] <= `SRAC_GUARD_DEFAULT;
      regs[`SRAC_ADR_ACK_CFG] <= `SRAC_ACK_CFG_DEFAULT;
      regs[`SRAC_ADR_FLAG_ERR] <= `SRAC_FLAG_ERR_DEFAULT;
      nvm_program_mode_o <= 1'b0;
    end else begin
      if (we && cadr != `SRAC_ADR_CMD) regs[cadr] <= cdat;
      if (we && cadr == `SRAC_ADR_NVM_CTRL) nvm_program_mode_o <= cdat[0];
      for (int i = 0; i < 256; i++) begin
        case (srac_group_of(8'(i)))
          SRAC_GRP_BRT: begin
            if (brt_reload) regs[i] <= nv[i];
            else if (ev_restore) regs[i] <= 8'h00;
          end
          SRAC_GRP_CUR, SRAC_GRP_CFG, SRAC_GRP_CFG_NV: begin
            if (cc_reload) regs[i] <= nv[i];
          end
          SRAC_GRP_CTRL, SRAC_GRP_FLAG: begin
            if (uvlo_restart_i) regs[i] <= 8'h00;
          end
          default: ;
        endcase
      end
      if (uvlo_restart_i) begin
        regs[`SRAC_ADR_GUARD] <= `SRAC_GUARD_DEFAULT;
        regs[`SRAC_ADR_ACK_CFG] <= `SRAC_ACK_CFG_DEFAULT;
        regs[`SRAC_ADR_FLAG_ERR] <= `SRAC_FLAG_ERR_DEFAULT;
        nvm_program_mode_o <= 1'b0;
      end else if (ev_prog) begin
        regs[`SRAC_ADR_GUARD] <= 8'h00;
      end else if (wdt_overflow_i || ev_force || (we && cadr == `SRAC_ADR_CTRL_GATE)) begin
        regs[`SRAC_ADR_GUARD] <= `SRAC_GUARD_DEFAULT;
      end
      if (ev_restore && !uvlo_restart_i) begin
        regs[`SRAC_ADR_FLAG_ERR] <= regs[`SRAC_ADR_FLAG_ERR] & 8'hfe;
      end
    end
  end

  assign link.d2h_vld = tx_vld_r;
  assign link.d2h_byte = tx_byte_r;
  assign link.d2h_busy = busy_r;
endmodule // srac_device

// [srac_host.sv]
`timescale 1ns/100ps
`include "srac_consts.svh"
module srac_host import srac_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  srac_link_if.host link
);
  // ***********************************************************
  // Avalon slave and frame sequencer
  // ***********************************************************
  logic [7:0] buf_r [0:`SRAC_BUF_DEPTH-1];
  srac_host_state_e state_r, state_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic ack_r, ack_nxt, crcerr_r, crcerr_nxt, tmo_r, tmo_nxt;
  logic [7:0] stat_r, stat_nxt, crc_r, crc_nxt, tmr_r, tmr_nxt;
  logic [7:0] tx_r, tx_nxt, rdata_nxt_b;
  logic tx_vld_r, tx_vld_nxt, wait_nxt;
  logic [4:0] cnt_r, cnt_nxt, len, exp;
  logic [31:0] rdata_nxt;
  logic req, acc, bufsel, bufwr, rxwr;
  logic [4:0] bidx, rxidx;
  logic [7:0] boff;

  always_comb begin
    req = avs_read_i || avs_write_i;
    acc = req && !avs_waitrequest_o;
    wait_nxt = !(req && avs_waitrequest_o);
    boff = avs_address_i - `SRAC_H_BUF;
    bidx = boff[6:2];
    bufsel = avs_address_i >= `SRAC_H_BUF && !boff[7] && bidx < 5'(`SRAC_BUF_DEPTH);
    len = srac_len_bytes(cmd_r[5:4]);
    exp = !cmd_r[`SRAC_HDR_RW_BIT] ? len + 5'd1 :
          (ack_r && !cmd_r[`SRAC_HDR_BCAST_BIT]) ? 5'd2 : 5'd0;
    rdata_nxt_b = bufsel ? buf_r[bidx] : 8'h00;
    rdata_nxt = {24'h0, rdata_nxt_b};
    if (avs_address_i == `SRAC_H_CMD) rdata_nxt = {15'h0, ack_r, cmd_r};
    if (avs_address_i == `SRAC_H_STAT) begin
      rdata_nxt = {16'h0, stat_r, 5'h0, tmo_r, crcerr_r, state_r != SRAC_H_IDLE};
    end
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    ack_nxt = ack_r;
    crcerr_nxt = crcerr_r;
    tmo_nxt = tmo_r;
    stat_nxt = stat_r;
    crc_nxt = crc_r;
    tmr_nxt = tmr_r;
    tx_nxt = tx_r;
    tx_vld_nxt = 1'b0;
    cnt_nxt = cnt_r;
    rxwr = 1'b0;
    rxidx = cnt_r;
    unique case (state_r)
      SRAC_H_IDLE: begin
        if (acc && avs_write_i && avs_address_i == `SRAC_H_CMD &&
            avs_writedata_i[`SRAC_H_CMD_GO_BIT]) begin
          cmd_nxt = avs_writedata_i[15:0];
          ack_nxt = avs_writedata_i[`SRAC_H_CMD_ACK_BIT];
          crcerr_nxt = 1'b0;
          tmo_nxt = 1'b0;
          state_nxt = SRAC_H_SYNC;
        end
      end
      SRAC_H_SYNC: begin
        if (!link.d2h_busy) begin
          tx_vld_nxt = 1'b1;
          tx_nxt = `SRAC_SYNC_BYTE;
          crc_nxt = `SRAC_CRC_SEED;
          state_nxt = SRAC_H_HDR;
        end
      end
      SRAC_H_HDR: begin
        tx_vld_nxt = 1'b1;
        tx_nxt = cmd_r[7:0];
        crc_nxt = srac_crc_step(crc_r, cmd_r[7:0]);
        state_nxt = SRAC_H_ADR;
      end
      SRAC_H_ADR: begin
        tx_vld_nxt = 1'b1;
        tx_nxt = cmd_r[15:8];
        crc_nxt = srac_crc_step(crc_r, cmd_r[15:8]);
        cnt_nxt = 5'd0;
        state_nxt = cmd_r[`SRAC_HDR_RW_BIT] ? SRAC_H_DATA : SRAC_H_CRC;
      end
      SRAC_H_DATA: begin
        tx_vld_nxt = 1'b1;
        tx_nxt = buf_r[cnt_r];
        crc_nxt = srac_crc_step(crc_r, buf_r[cnt_r]);
        cnt_nxt = cnt_r + 5'd1;
        if (cnt_r == len - 5'd1) state_nxt = SRAC_H_CRC;
      end
      SRAC_H_CRC: begin
        tx_vld_nxt = 1'b1;
        tx_nxt = crc_r;
        crc_nxt = `SRAC_CRC_SEED;
        cnt_nxt = 5'd0;
        tmr_nxt = 8'd0;
        state_nxt = (exp == 5'd0) ? SRAC_H_IDLE : SRAC_H_WAIT;
      end
      SRAC_H_WAIT: begin
        tmr_nxt = tmr_r + 8'd1;
        if (link.d2h_vld) begin
          tmr_nxt = 8'd0;
          cnt_nxt = cnt_r + 5'd1;
          crc_nxt = srac_crc_step(crc_r, link.d2h_byte);
          if (cnt_r == exp - 5'd1) begin
            crcerr_nxt = (link.d2h_byte != crc_r);
            state_nxt = SRAC_H_IDLE;
          end else if (cmd_r[`SRAC_HDR_RW_BIT]) begin
            stat_nxt = link.d2h_byte;
          end else begin
            rxwr = 1'b1;
          end
        end else if (tmr_r == `SRAC_RSP_TIMEOUT) begin
          tmo_nxt = 1'b1;
          state_nxt = SRAC_H_IDLE;
        end
      end
      default: state_nxt = SRAC_H_IDLE;
    endcase
    bufwr = acc && avs_write_i && bufsel && state_r == SRAC_H_IDLE;
  end

  always_ff @(posedge core_clk_i) begin
    if (bufwr) buf_r[bidx] <= avs_writedata_i[7:0];
    else if (rxwr) buf_r[rxidx] <= link.d2h_byte;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= SRAC_H_IDLE;
      cmd_r <= 16'h0000;
      ack_r <= 1'b0;
      crcerr_r <= 1'b0;
      tmo_r <= 1'b0;
      stat_r <= 8'h00;
      crc_r <= `SRAC_CRC_SEED;
      tmr_r <= 8'd0;
      tx_r <= 8'h00;
      tx_vld_r <= 1'b0;
      cnt_r <= 5'd0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      ack_r <= ack_nxt;
      crcerr_r <= crcerr_nxt;
      tmo_r <= tmo_nxt;
      stat_r <= stat_nxt;
      crc_r <= crc_nxt;
      tmr_r <= tmr_nxt;
      tx_r <= tx_nxt;
      tx_vld_r <= tx_vld_nxt;
      cnt_r <= cnt_nxt;
      avs_waitrequest_o <= wait_nxt;
      if (req && avs_waitrequest_o) avs_readdata_o <= rdata_nxt;
    end
  end

  assign link.h2d_vld = tx_vld_r;
  assign link.h2d_byte = tx_r;
endmodule // srac_host

// [srac_properties.sv]
`timescale 1ns/100ps
module srac_properties (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic h2d_vld,
  input wire logic [7:0] h2d_byte,
  input wire logic d2h_vld,
  input wire logic [7:0] d2h_byte,
  input wire logic d2h_busy
);
  logic [7:0] rcrc_r, rcrc_nxt, hcrc_r, hcrc_nxt;
  logic [5:0] left_r, left_nxt;
  function automatic logic [7:0] crc_next(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] v;
    v = c ^ d;
    for (int i = 0; i < 8; i++) v = v[7] ? ((v << 1) ^ 8'h07) : (v << 1);
    return v;
  endfunction
  // *********************************
  // Running check codes of both directions
  // *********************************
  always_comb begin
    rcrc_nxt = d2h_busy ? rcrc_r : 8'hff;
    hcrc_nxt = hcrc_r;
    left_nxt = left_r;
    if (d2h_vld) rcrc_nxt = crc_next(rcrc_r, d2h_byte);
    // Bytes still owed by the frame; 0 expects sync, 63 expects header
    if (h2d_vld && left_r == 6'd0) begin
      hcrc_nxt = 8'hff;
      left_nxt = 6'd63;
    end else if (h2d_vld) begin
      hcrc_nxt = crc_next(hcrc_r, h2d_byte);
      left_nxt = left_r - 6'd1;
      if (left_r == 6'd63) begin
        left_nxt = !h2d_byte[7] ? 6'd2 : h2d_byte[5] ? (h2d_byte[4] ? 6'd26 : 6'd18) :
                   (h2d_byte[4] ? 6'd6 : 6'd3);
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    rcrc_r <= rst_i ? 8'hff : rcrc_nxt;
    hcrc_r <= rst_i ? 8'hff : hcrc_nxt;
    left_r <= rst_i ? 6'd0 : left_nxt;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence reply_pair;
    d2h_vld ##1 d2h_vld;
  endsequence
  sequence reply_end;
    d2h_vld ##1 !d2h_vld;
  endsequence
  chk_vld_in_busy: assert property (d2h_vld |-> d2h_busy)
    else $error("reply byte outside busy");
  chk_reply_late: assert property ($rose(d2h_busy) |-> !d2h_vld)
    else $error("reply byte too early");
  chk_reply_pair: assert property ($rose(d2h_vld) |-> reply_pair)
    else $error("reply shorter than two bytes");
  chk_reply_crc: assert property (reply_end |-> rcrc_r == 8'h00)
    else $error("reply check byte wrong");
  chk_reply_close: assert property (reply_end |-> ##[0:2] !d2h_busy)
    else $error("busy stays after reply");
  chk_busy_bound: assert property ($rose(d2h_busy) |-> ##[1:80] !d2h_busy)
    else $error("busy too long");
  chk_sync_first: assert property (h2d_vld && left_r == 6'd0 |-> h2d_byte == 8'h55)
    else $error("frame without sync byte");
  chk_host_crc: assert property ($rose(d2h_busy) |-> hcrc_r == 8'h00)
    else $error("frame check byte wrong");
  chk_host_quiet: assert property (d2h_busy |-> !h2d_vld)
    else $error("byte sent while busy");
endmodule // srac_properties

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rst = 1, rd = 0, wr = 0, refs = 0, uv = 0, wd = 0, ws, nvm, wdt;
  logic [2:0] strap = 3'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic [7:0] ck [4] = '{8'h43, 8'h4f, 8'h44, 8'h45};
  logic [7:0] nk [6] = '{8'h00, 8'h04, 8'h02, 8'h09, 8'h02, 8'h09};
  int fail_count = 0, compares = 0, wdt_n = 0, n0;
  srac_link_if lnk ();
  srac_device srac_device_i (.core_clk_i(clk), .rst_i(rst), .ref_sel_i(refs), .addr_strap_i(strap),
    .uvlo_restart_i(uv), .wdt_overflow_i(wd), .wdt_restart_o(wdt), .nvm_program_mode_o(nvm),
    .link(lnk));
  srac_host srac_host_i (.core_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(ws),
    .link(lnk));
  srac_properties srac_properties_i (.core_clk_i(clk), .rst_i(rst), .h2d_vld(lnk.h2d_vld),
    .h2d_byte(lnk.h2d_byte), .d2h_vld(lnk.d2h_vld), .d2h_byte(lnk.d2h_byte),
    .d2h_busy(lnk.d2h_busy));
  always #25 clk = ~clk;
  always @(posedge clk) if (wdt === 1'b1) wdt_n <= wdt_n + 1;
  // *********************************
  // Bus and frame tasks
  // *********************************
  task summarize;
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task av(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    @(posedge clk);
    while (ws !== 1'b0) begin
      k++;
      if (k > 20) begin
        fail_count++;
        summarize;
      end
      @(posedge clk);
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task xf(input logic [7:0] h, input logic [7:0] ra);
    int k;
    av(8'h00, 1'b1, {1'b1, 14'h0, 1'b1, ra, h});
    for (k = 0; k < 200; k++) begin
      av(8'h04, 1'b0, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (k == 200) begin
      fail_count++;
      summarize;
    end
  endtask
  task wr1(input logic [7:0] ra, input logic [7:0] d);
    av(8'h40, 1'b1, {24'h0, d});
    xf(8'h80, ra);
  endtask
  task rd1(input logic [7:0] ra, input logic [7:0] e);
    xf(8'h00, ra);
    av(8'h40, 1'b0, 32'h0);
    chk(q[7:0], e);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd1(8'h92, 8'h01);
    rd1(8'h93, 8'h06);
    wr1(8'h50, 8'h33);
    av(8'h04, 1'b0, 32'h0);
    chk(q[15:8], 8'h01);
    rd1(8'h50, 8'ha5);
    wr1(8'h95, 8'h77);
    rd1(8'h95, 8'h00);
    foreach (ck[i]) wr1(8'h96, ck[i]);
    wr1(8'h93, 8'h00);
    wr1(8'h50, 8'h33);
    rd1(8'h50, 8'h33);
    wr1(8'h96, 8'h00);
    rd1(8'h93, 8'h06);
    for (int i = 0; i < 4; i++) av(8'h40 + 8'(4 * i), 1'b1, 32'h10 + i);
    xf(8'h90, 8'h00);
    rd1(8'h03, 8'h13);
    xf(8'h10, 8'h01);
    for (int i = 0; i < 4; i++) begin
      av(8'h40 + 8'(4 * i), 1'b0, 32'h0);
      chk(q[7:0], (i < 3) ? 8'h11 + 8'(i) : 8'h00);
    end
    wr1(8'h91, 8'h01);
    rd1(8'h00, 8'h00);
    rd1(8'h50, 8'ha5);
    wr1(8'h91, 8'h02);
    rd1(8'h00, 8'ha5);
    wr1(8'h00, 8'h12);
    rd1(8'h00, 8'h12);
    wd <= 1'b1;
    @(posedge clk);
    wd <= 1'b0;
    rd1(8'h00, 8'ha5);
    xf(8'h20, 8'h00);
    xf(8'h30, 8'h00);
    av(8'h9c, 1'b0, 32'h0);
    chk(q[7:0], 8'ha5);
    wr1(8'h84, 8'h3c);
    rd1(8'h84, 8'ha5);
    foreach (nk[i]) wr1(8'h98, nk[i]);
    wr1(8'h97, 8'h01);
    chk(nvm, 1);
    rd1(8'h93, 8'h00);
    wr1(8'h84, 8'h3c);
    rd1(8'h84, 8'h3c);
    uv <= 1'b1;
    @(posedge clk);
    uv <= 1'b0;
    rd1(8'h93, 8'h06);
    rd1(8'h84, 8'ha5);
    chk(nvm, 0);
    n0 = wdt_n;
    av(8'h40, 1'b1, 32'h77);
    xf(8'h81, 8'h00);
    chk(q[2], 1);
    chk(wdt_n, n0);
    rd1(8'h00, 8'ha5);
    chk(wdt_n, n0 + 1);
    strap <= 3'h3;
    refs <= 1'b1;
    rd1(8'h92, 8'h01);
    summarize;
  end
endmodule // testbench
